// >>> rtl/lps_pin_share.sv
// led driver and debug clock pin share with session gating
`timescale 1ns/1ps
module lps_pin_share import lps_pkg::*; (
    input wire logic clock,
    input wire logic nrst,
    input wire logic led_request,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    input wire lps_dbg_req_t dbg_req,
    output lps_dbg_ans_t dbg_ans,
    output logic debug_clock_line,
    output logic debug_clock_rise,
    output logic connected
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser and edge finder
    logic sync1_r, sync1_nxt;
    logic sync2_r, sync2_nxt;
    logic prev_r, prev_nxt;

    always_comb begin
        sync1_nxt = pin_in;
        sync2_nxt = sync1_r;
        prev_nxt = sync2_r;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sync1_r <= LPS_PIN_HIGH;
            sync2_r <= LPS_PIN_HIGH;
            prev_r <= LPS_PIN_HIGH;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            prev_r <= prev_nxt;
        end
    end

    // host clock seen on the shared pin
    assign debug_clock_line = sync2_r;
    assign debug_clock_rise = sync2_r & ~prev_r;

    ////////////////////////////////////////////////////////////////////////
    // session decode shared by the led gate and the flag
    function automatic logic lps_in_session(
        input lps_state_t s
    );
        return (s == LPS_CONN);
    endfunction : lps_in_session

    ////////////////////////////////////////////////////////////////////////
    // session state machine
    lps_state_t state_r, state_nxt;
    lps_dbg_ans_t ans_r, ans_nxt;
    logic led_on_r, led_on_nxt;

    always_comb begin
        state_nxt = state_r;
        ans_nxt = '0;
        ans_nxt.halt = ans_r.halt;
        unique case (state_r)
            LPS_IDLE, LPS_REJ: begin
                state_nxt = LPS_IDLE;
                if (dbg_req.connect) begin
                    if (led_on_r) begin
                        state_nxt = LPS_REJ;
                        ans_nxt.refused = 1'b1;
                    end else begin
                        state_nxt = LPS_CONN;
                        ans_nxt.accepted = 1'b1;
                        ans_nxt.halt = 1'b1;
                    end
                end
            end
            LPS_CONN: begin
                ans_nxt.core_reset = dbg_req.reset_dev;
                if (dbg_req.disconnect) begin
                    state_nxt = LPS_IDLE;
                    ans_nxt.halt = 1'b0;
                end
            end
            default: begin
                state_nxt = LPS_IDLE;
                ans_nxt.halt = 1'b0;
            end
        endcase
    end

    always_comb begin
        led_on_nxt = led_request & ~lps_in_session(state_nxt);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r <= LPS_IDLE;
            ans_r <= '0;
            led_on_r <= LPS_SYNC_RST;
        end else begin
            state_r <= state_nxt;
            ans_r <= ans_nxt;
            led_on_r <= led_on_nxt;
        end
    end

    assign dbg_ans = ans_r;
    assign connected = lps_in_session(state_r);

    ////////////////////////////////////////////////////////////////////////
    // current sink pulls the shared pin low
    assign pin_out = 1'b0;
    assign pin_oe = led_on_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    // no drive while connected
    led_block_a: assert property (@(posedge clock) disable iff (!nrst)
        connected |-> !pin_oe) else $error("led driven during session");
    // connect with led on is refused
    conn_refuse_a: assert property (@(posedge clock) disable iff (!nrst)
        (!connected && dbg_req.connect && led_on_r) |=> (dbg_ans.refused && !connected))
        else $error("connect accepted with led on");
    conn_accept_a: assert property (@(posedge clock) disable iff (!nrst)
        (!connected && dbg_req.connect && !led_on_r) |=> (connected && dbg_ans.halt))
        else $error("connect not accepted");
    disc_release_a: assert property (@(posedge clock) disable iff (!nrst)
        (connected && dbg_req.disconnect) |=> (!connected && !dbg_ans.halt))
        else $error("disconnect not released");
    led_follow_a: assert property (@(posedge clock) disable iff (!nrst)
        ($past(nrst) && !connected && $past(!connected) && $past(led_request)) |-> pin_oe)
        else $error("led not following request");
    // pin drive never rises in session
    pin_quiet_a: assert property (@(posedge clock) disable iff (!nrst)
        connected[*2] |-> !$rose(pin_oe)) else $error("pin activity from led in session");
    halt_flag_a: assert property (@(posedge clock) disable iff (!nrst)
        dbg_ans.halt == connected) else $error("halt and flag disagree");
    dev_reset_a: assert property (@(posedge clock) disable iff (!nrst)
        (connected && dbg_req.reset_dev) |=> dbg_ans.core_reset)
        else $error("device reset lost");
    // clock edge follows pin two cycles late
    clk_sync_a: assert property (@(posedge clock) disable iff (!nrst)
        debug_clock_rise |-> $past(pin_in, 2) && !$past(pin_in, 3))
        else $error("clock edge misaligned");

    ////////////////////////////////////////////////////////////////////////
    // answer and gating checks
    // refusal leaves no session
    refuse_state_a: assert property (@(posedge clock) disable iff (!nrst)
        dbg_ans.refused |-> !connected) else $error("refused but connected");

    accept_state_a: assert property (@(posedge clock) disable iff (!nrst)
        dbg_ans.accepted |-> connected) else $error("accepted but no flag");

    ans_exclusive_a: assert property (@(posedge clock) disable iff (!nrst)
        !(dbg_ans.accepted && dbg_ans.refused)) else $error("both answers at once");

    led_gate_a: assert property (@(posedge clock) disable iff (!nrst)
        pin_oe |-> $past(led_request)) else $error("led driven without request");

    block_release_a: assert property (@(posedge clock) disable iff (!nrst)
        (connected && dbg_req.disconnect && led_request) |=> pin_oe)
        else $error("led block not removed");

    // core reset only from a session
    reset_source_a: assert property (@(posedge clock) disable iff (!nrst)
        dbg_ans.core_reset |-> ($past(connected) && $past(dbg_req.reset_dev)))
        else $error("core reset without request");

    session_hold_a: assert property (@(posedge clock) disable iff (!nrst)
        (connected && !dbg_req.disconnect) |=> connected) else $error("session dropped");

    idle_hold_a: assert property (@(posedge clock) disable iff (!nrst)
        (!connected && !dbg_req.connect) |=> !connected) else $error("session from nowhere");

    pin_sink_a: assert property (@(posedge clock) disable iff (!nrst)
        pin_oe |-> !pin_out) else $error("sink drives high");

    rise_pulse_a: assert property (@(posedge clock) disable iff (!nrst)
        debug_clock_rise |=> !debug_clock_rise) else $error("edge pulse too long");

    rise_level_a: assert property (@(posedge clock) disable iff (!nrst)
        debug_clock_rise |-> debug_clock_line) else $error("edge with line low");

    refuse_pulse_a: assert property (@(posedge clock) disable iff (!nrst)
        dbg_ans.refused |=> (!dbg_ans.refused || $past(dbg_req.connect)))
        else $error("refusal pulse too long");

    accept_once_a: assert property (@(posedge clock) disable iff (!nrst)
        dbg_ans.accepted |=> !dbg_ans.accepted) else $error("acceptance pulse too long");

    refuse_keep_a: assert property (@(posedge clock) disable iff (!nrst)
        (pin_oe && led_request && dbg_req.connect) |=> !connected)
        else $error("connect taken with led held on");

    halt_fall_a: assert property (@(posedge clock) disable iff (!nrst)
        $fell(connected) |-> $fell(dbg_ans.halt)) else $error("halt kept after disconnect");

endmodule : lps_pin_share

// >>> rtl/lps_pkg.sv
// constants and types for the led and debug clock pin share
package lps_pkg;

    // session states, one-hot
    typedef enum logic [2:0] {
        LPS_IDLE = 3'h1,
        LPS_CONN = 3'h2,
        LPS_REJ = 3'h4
    } lps_state_t;

    // debug request group from the adapter side logic
    typedef struct packed {
        logic connect;
        logic disconnect;
        logic reset_dev;
    } lps_dbg_req_t;

    // answer group to the core
    typedef struct packed {
        logic halt;
        logic accepted;
        logic refused;
        logic core_reset;
    } lps_dbg_ans_t;

    localparam logic LPS_PIN_HIGH = 1'h1;
    localparam logic LPS_SYNC_RST = 1'h0;

endpackage : lps_pkg

// >>> tb/lps_host_model.sv
// debug adapter host model driving the shared clock pin
`timescale 1ns/1ps
module lps_host_model (
    input wire logic frame,
    output logic line,
    output int rises
);
    // host clock line
    // toggles only inside a frame, idles high
    initial begin
        line = 1'h1;
        rises = 0;
        #137;
        forever begin
            #400 line = frame ? ~line : 1'h1;
        end
    end
    // host side count of clock rises
    always @(posedge line) rises++;
endmodule : lps_host_model

// >>> tb/led_debug_clock_pin_share_test.sv
// bench for the led and debug clock pin share
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
module led_debug_clock_pin_share_test import lps_pkg::*;;
    logic clock = 1'h0, nrst = 1'h0, led_request = 1'h0, frame = 1'h0;
    logic pin_out, pin_oe, debug_clock_line, debug_clock_rise, connected, host_line;
    lps_dbg_req_t dbg_req = '0;
    lps_dbg_ans_t dbg_ans;
    int rises, num_errors = 0, checked = 0, seen, base;
    // shared pin: led sink pulls low, else the host clock
    wire logic pin_in = pin_oe ? pin_out : host_line;
    lps_pin_share i_dut (.clock, .nrst, .led_request, .pin_in, .pin_out, .pin_oe,
        .dbg_req, .dbg_ans, .debug_clock_line, .debug_clock_rise, .connected);
    lps_host_model i_host (.frame, .line(host_line), .rises);
    // 10 MHz clock
    always #50 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////
    task automatic req(input lps_dbg_req_t r);
        @(posedge clock) dbg_req <= r;
        @(posedge clock) dbg_req <= '0;
        #1;
    endtask : req
    task automatic count(input int n);
        repeat (n) begin
            @(posedge clock);
            #1 seen += (debug_clock_rise === 1'h1);
        end
    endtask : count
    task automatic t_session;
        req(3'h4);
        `CHK("accepted", 1'h1, dbg_ans.accepted)
        `CHK("connected", 1'h1, connected)
        @(posedge clock) led_request <= 1'h1;
        repeat (3) @(posedge clock);
        #1 `CHK("oe blocked", 1'h0, pin_oe)
        req(3'h1);
        `CHK("core reset", 1'h1, dbg_ans.core_reset)
        req(3'h2);
        `CHK("halt", 1'h0, dbg_ans.halt)
        `CHK("disconnected", 1'h0, connected)
        @(posedge clock) #1 `CHK("oe follows", 1'h1, pin_oe)
        `CHK("pin sink", 1'h0, pin_out)
        $display("t_session done");
    endtask : t_session
    task automatic t_refuse;
        req(3'h4);
        `CHK("refused", 1'h1, dbg_ans.refused)
        `CHK("not connected", 1'h0, connected)
        @(posedge clock) nrst <= 1'h0;
        #1 `CHK("oe reset", 1'h0, pin_oe)
        @(posedge clock) nrst <= 1'h1;
        @(posedge clock) led_request <= 1'h0;
        repeat (2) @(posedge clock);
        req(3'h4);
        `CHK("accepted after", 1'h1, dbg_ans.accepted)
        $display("t_refuse done");
    endtask : t_refuse
    task automatic t_clock;
        @(posedge clock) led_request <= 1'h1;
        seen = 0;
        base = rises;
        frame = 1'h1;
        count(60);
        frame = 1'h0;
        count(25);
        `CHK("rises", rises - base, seen)
        `CHK("oe quiet", 1'h0, pin_oe)
        `CHK("clock line", host_line, debug_clock_line)
        req(3'h2);
        $display("t_clock done");
    endtask : t_clock
    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize
    // main sequence
    initial begin
        repeat (3) @(posedge clock);
        nrst <= 1'h1;
        t_session();
        t_refuse();
        t_clock();
        summarize();
    end
endmodule : led_debug_clock_pin_share_test
